// ===== design/opw_port.sv
/*
 * Device-side 8080-style parallel host port of an OLED display module.
 * Bus pins are synchronised to the core clock, write bytes are tagged
 * with the data/command level and queued, and reads return either the
 * display byte or a status byte supplied by the core.
 * Assumes the host keeps its own sequencing: straps high before reset
 * release, reset held long after power-up, and strobes slower than the
 * synchroniser delay.
 */
`timescale 1ns/100ps
`default_nettype none

module opw_port (
    // Clock and reset; reset doubles as the module initialisation pin.
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // Host bus control pins, all active low except data/command.
    input  wire logic                       chipSelN,
    input  wire logic                       wrStrobeN,
    input  wire logic                       rdStrobeN,
    input  wire logic                       dcSel,
    // Two-way parallel byte lines.
    input  wire logic [opw_pkg::BYTE_W-1:0] parallelByteLinesIn,
    output logic      [opw_pkg::BYTE_W-1:0] parallelByteLinesOut,
    output logic                            parallelByteLinesOe,
    // Bus-mode straps.
    input  wire logic                       busModeStrapOne,
    input  wire logic                       busModeStrapTwo,
    // Written bytes toward the display core.
    output logic                            outValid,
    input  wire logic                       outReady,
    output logic                            outIsData,
    output logic      [opw_pkg::BYTE_W-1:0] outByte,
    // Read requests toward the display core.
    output logic                            readReq,
    output logic                            readIsData,
    output logic                            readDone,
    input  wire logic [opw_pkg::BYTE_W-1:0] displayReadByte,
    input  wire logic [opw_pkg::BYTE_W-1:0] statusByte,
    // Status.
    output logic                            overrun,
    output logic                            modeSelected
);

    import opw_pkg::*;

    // Synchronised pin levels.
    logic [SYNC_W-1:0] pinSync;
    logic              csLow;
    logic              wrLow;
    logic              rdLow;
    logic              dcHigh;
    logic [BYTE_W-1:0] busByte;

    // Strap capture state.
    logic [1:0]        settle_q;
    logic [1:0]        settle_d;
    logic              strapDone_q;
    logic              strapDone_d;
    logic              modeSel_q;
    logic              modeSel_d;

    // Transfer state.
    opw_state_t        state_q;
    opw_state_t        state_d;
    logic [WORD_W-1:0] hold_q;
    logic [WORD_W-1:0] hold_d;
    logic              pendValid_q;
    logic              pendValid_d;
    logic [WORD_W-1:0] pendWord_q;
    logic [WORD_W-1:0] pendWord_d;
    logic              overrun_q;
    logic              overrun_d;
    logic [BYTE_W-1:0] drvByte_q;
    logic [BYTE_W-1:0] drvByte_d;
    logic              drvEn_q;
    logic              drvEn_d;
    logic              readReq_q;
    logic              readReq_d;
    logic              readIsData_q;
    logic              readIsData_d;
    logic              readDone_q;
    logic              readDone_d;
    logic              busEnabled;
    logic              writeEnd;

    // Queue and output stage.
    logic              fifoInReady;
    logic              fifoOutValid;
    logic              fifoOutReady;
    logic [WORD_W-1:0] fifoOutData;
    logic              outValid_q;
    logic              outValid_d;
    logic [WORD_W-1:0] outWord_q;
    logic [WORD_W-1:0] outWord_d;

    // Every pin passes two flip-flops before any logic reads it.
    opw_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .rawIn    ({parallelByteLinesIn, busModeStrapTwo, busModeStrapOne,
                    dcSel, rdStrobeN, wrStrobeN, chipSelN}),
        .syncOut  (pinSync)
    );

    // Decoded pin levels.
    always_comb begin
        csLow   = !pinSync[SY_CS];
        wrLow   = !pinSync[SY_WR];
        rdLow   = !pinSync[SY_RD];
        dcHigh  = pinSync[SY_DC];
        busByte = pinSync[SY_DATA_LSB +: BYTE_W];
    end

    // Straps are taken once the synchronisers hold post-release levels.
    always_comb begin
        settle_d    = settle_q;
        strapDone_d = strapDone_q;
        modeSel_d   = modeSel_q;
        if (!strapDone_q) begin
            if (settle_q == STRAP_SETTLE) begin
                strapDone_d = 1'b1;
                modeSel_d   = pinSync[SY_S1] && pinSync[SY_S2];
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
    end

    // Strap registers; a new reset takes the straps again.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q    <= 2'h0;
            strapDone_q <= 1'b0;
            modeSel_q   <= 1'b0;
        end else begin
            settle_q    <= settle_d;
            strapDone_q <= strapDone_d;
            modeSel_q   <= modeSel_d;
        end
    end

    // The bus is heard only in 8080 mode with the straps settled.
    assign busEnabled = strapDone_q && modeSel_q;

    // A write ends when its strobe rises or the chip is deselected.
    assign writeEnd = (state_q == ST_WRITE) && (!wrLow || !csLow);

    // Transfer sequencing, write capture and read drive.
    always_comb begin
        state_d      = state_q;
        hold_d       = hold_q;
        pendValid_d  = pendValid_q && !fifoInReady;
        pendWord_d   = pendWord_q;
        overrun_d    = 1'b0;
        drvByte_d    = drvByte_q;
        drvEn_d      = 1'b0;
        readReq_d    = 1'b0;
        readIsData_d = readIsData_q;
        readDone_d   = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // Nothing starts while deselected.
                if (busEnabled && csLow) begin
                    if (wrLow) begin
                        state_d = ST_WRITE;
                        hold_d  = {dcHigh, busByte};
                    end else if (rdLow) begin
                        state_d      = ST_READ;
                        readReq_d    = 1'b1;
                        readIsData_d = dcHigh;
                    end
                end
            end
            ST_WRITE: begin
                if (writeEnd) begin
                    // The last sample taken while the strobe was low is kept.
                    state_d = ST_IDLE;
                    if (pendValid_q && !fifoInReady) begin
                        overrun_d = 1'b1;
                    end else begin
                        pendValid_d = 1'b1;
                        pendWord_d  = hold_q;
                    end
                end else begin
                    hold_d = {dcHigh, busByte};
                end
            end
            ST_READ: begin
                if (!rdLow || !csLow) begin
                    state_d    = ST_IDLE;
                    readDone_d = 1'b1;
                end else begin
                    // Display byte when data is selected, else status.
                    drvEn_d   = 1'b1;
                    drvByte_d = readIsData_q ? displayReadByte : statusByte;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Transfer registers.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q      <= ST_IDLE;
            hold_q       <= WORD_RST;
            pendValid_q  <= 1'b0;
            pendWord_q   <= WORD_RST;
            overrun_q    <= 1'b0;
            drvByte_q    <= BYTE_RST;
            drvEn_q      <= 1'b0;
            readReq_q    <= 1'b0;
            readIsData_q <= 1'b0;
            readDone_q   <= 1'b0;
        end else begin
            state_q      <= state_d;
            hold_q       <= hold_d;
            pendValid_q  <= pendValid_d;
            pendWord_q   <= pendWord_d;
            overrun_q    <= overrun_d;
            drvByte_q    <= drvByte_d;
            drvEn_q      <= drvEn_d;
            readReq_q    <= readReq_d;
            readIsData_q <= readIsData_d;
            readDone_q   <= readDone_d;
        end
    end

    // Queue between bus capture and the display core.
    opw_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .inValid  (pendValid_q),
        .inReady  (fifoInReady),
        .inData   (pendWord_q),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // Registered output stage keeps the core side straight from flops.
    assign fifoOutReady = !outValid_q || outReady;

    always_comb begin
        outValid_d = outValid_q && !outReady;
        outWord_d  = outWord_q;
        if (fifoOutValid && fifoOutReady) begin
            outValid_d = 1'b1;
            outWord_d  = fifoOutData;
        end
    end

    // Output stage registers.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            outValid_q <= 1'b0;
            outWord_q  <= WORD_RST;
        end else begin
            outValid_q <= outValid_d;
            outWord_q  <= outWord_d;
        end
    end

    // Port outputs.
    assign parallelByteLinesOut = drvByte_q;
    assign parallelByteLinesOe  = drvEn_q;
    assign outValid             = outValid_q;
    assign outIsData            = outWord_q[WORD_DC_BIT];
    assign outByte              = outWord_q[BYTE_W-1:0];
    assign readReq              = readReq_q;
    assign readIsData           = readIsData_q;
    assign readDone             = readDone_q;
    assign overrun              = overrun_q;
    assign modeSelected         = modeSel_q;

endmodule

`default_nettype wire

// ===== inc/opw_pkg.sv
/*
 * Shared constants and types of the OLED parallel host write port.
 * Assumes a single core clock at 20 MHz and an 8080-style bus on pins
 * that are asynchronous to that clock.
 */
package opw_pkg;

    // Core clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 50;

    // Width of the parallel byte lines.
    localparam int BYTE_W = 8;

    // A queued word holds the data/command level above the byte.
    localparam int WORD_W = BYTE_W + 1;
    localparam int WORD_DC_BIT = BYTE_W;

    // Depth of the write queue.
    localparam int FIFO_DEPTH = 4;

    // Number of flip-flops in each pin synchroniser.
    localparam int SYNC_STAGES = 2;

    // Bit positions inside the synchronised pin bundle.
    localparam int SY_CS = 0;
    localparam int SY_WR = 1;
    localparam int SY_RD = 2;
    localparam int SY_DC = 3;
    localparam int SY_S1 = 4;
    localparam int SY_S2 = 5;
    localparam int SY_DATA_LSB = 6;
    localparam int SYNC_W = SY_DATA_LSB + BYTE_W;

    // Pin bundle value during reset: strobes and chip select idle high.
    localparam logic [SYNC_W-1:0] SYNC_RST = 14'h0007;

    // Reset values of the byte and word registers.
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 9'h000;

    // Cycles after reset release before the straps are taken.
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // Transfer states of the bus port.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ
    } opw_state_t;

endpackage

// ===== design/opw_sync.sv
/*
 * Multi-bit two-stage pin synchroniser, one chain per bit.
 * Assumes every bit is an independent level from outside the core clock;
 * the reset value of each chain is a constant parameter.
 */
`timescale 1ns/100ps
`default_nettype none

module opw_sync #(
    parameter int                WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Raw and synchronised levels.
    input  wire logic [WIDTH-1:0]  rawIn,
    output logic      [WIDTH-1:0]  syncOut
);

    // One chain per bit; the first stage feeds only the second stage.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic metaQ;
            logic stableQ;
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    metaQ   <= RST_VAL[gi];
                    stableQ <= RST_VAL[gi];
                end else begin
                    metaQ   <= rawIn[gi];
                    stableQ <= metaQ;
                end
            end
            assign syncOut[gi] = stableQ;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== design/opw_fifo.sv
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two; push and pop may occur in one cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module opw_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Filling side.
    input  wire logic              inValid,
    output logic                   inReady,
    input  wire logic [WIDTH-1:0]  inData,
    // Draining side.
    output logic                   outValid,
    input  wire logic              outReady,
    output logic      [WIDTH-1:0]  outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      wrPtr_d;
    logic [AW:0]      rdPtr_q;
    logic [AW:0]      rdPtr_d;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    // Full when the pointers differ only in the wrap bit, empty when they are equal.
    always_comb begin
        full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
        empty    = (wrPtr_q == rdPtr_q);
        inReady  = !full;
        outValid = !empty;
        outData  = mem[rdPtr_q[AW-1:0]];
        push     = inValid && !full;
        pop      = outReady && !empty;
        wrPtr_d  = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d  = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    end

    // Pointer registers.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    // Storage needs no reset; empty guards every read.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

endmodule

`default_nettype wire

// ===== bench/opw_port_asserts.sv
/* Assertions on the ports of the parallel host port.
   Assumes it is bound to opw_port and sees one clock and one reset. */
`timescale 1ns/100ps
`default_nettype none
module opw_port_asserts (
    // Clock and reset.
    input wire logic                       core_clk,
    input wire logic                       arst_n,
    // Host pins.
    input wire logic                       chipSelN,
    input wire logic                       rdStrobeN,
    input wire logic [opw_pkg::BYTE_W-1:0] parallelByteLinesOut,
    input wire logic                       parallelByteLinesOe,
    // Core side.
    input wire logic                       outValid,
    input wire logic                       outReady,
    input wire logic                       outIsData,
    input wire logic [opw_pkg::BYTE_W-1:0] outByte,
    input wire logic                       readReq,
    input wire logic                       readIsData,
    input wire logic                       readDone,
    input wire logic [opw_pkg::BYTE_W-1:0] displayReadByte,
    input wire logic [opw_pkg::BYTE_W-1:0] statusByte,
    input wire logic                       modeSelected
);
    logic [2:0] csHigh_q;
    logic [2:0] csHigh_d;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Counts edges with chip select released, saturating at seven.
    always_comb csHigh_d = chipSelN ? (csHigh_q == 3'h7 ? csHigh_q : csHigh_q + 3'h1) : 3'h0;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) csHigh_q <= 3'h0;
        else csHigh_q <= csHigh_d;
    end
    property p_req_pulse; readReq |=> !readReq && parallelByteLinesOe && !readDone; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("read start not followed by drive");
    property p_oe_cause; parallelByteLinesOe |-> !$past(rdStrobeN, 3) || !$past(rdStrobeN, 4);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("byte lines driven without read");
    property p_rd_byte;
        parallelByteLinesOe |->
            parallelByteLinesOut == ($past(readIsData) ? $past(displayReadByte) : $past(statusByte));
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("wrong byte on read");
    property p_cs_quiet; csHigh_q >= 3'h5 |-> !readReq && !parallelByteLinesOe; endproperty
    a_cs_quiet: assert property (p_cs_quiet) else $error("activity while unselected");
    property p_done_fall; $fell(parallelByteLinesOe) |-> readDone ##1 !readDone; endproperty
    a_done_fall: assert property (p_done_fall) else $error("read end not flagged once");
    property p_out_hold;
        outValid && !outReady |=> outValid && $stable(outByte) && $stable(outIsData);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("written word lost before taken");
    property p_mode_gate; !modeSelected |-> !outValid && !readReq && !parallelByteLinesOe;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("bus served before mode set");
    property p_mode_stay; modeSelected |=> modeSelected; endproperty
    a_mode_stay: assert property (p_mode_stay) else $error("mode lost with static straps");
    property p_idle_oe; $fell(readReq) |-> ##[1:2] parallelByteLinesOe; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("read drive missing");
endmodule
bind opw_port opw_port_asserts opw_port_asserts_i (.core_clk, .arst_n, .chipSelN, .rdStrobeN,
    .parallelByteLinesOut, .parallelByteLinesOe, .outValid, .outReady, .outIsData, .outByte,
    .readReq, .readIsData, .readDone, .displayReadByte, .statusByte, .modeSelected);
`default_nettype wire

// ===== bench/opw_host_model.sv
/* Host controller model driving the 8080-style pins of the port.
   Assumes the caller enters its tasks just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module opw_host_model (
    // Clock.
    input wire logic                       core_clk,
    // Module side of the byte lines.
    input wire logic                       parallelByteLinesOe,
    input wire logic [opw_pkg::BYTE_W-1:0] parallelByteLinesOut,
    // Pins driven by the host.
    output logic                           chipSelN,
    output logic                           wrStrobeN,
    output logic                           rdStrobeN,
    output logic                           dcSel,
    output logic [opw_pkg::BYTE_W-1:0]     busLine,
    output logic                           busModeStrapOne,
    output logic                           busModeStrapTwo
);
    logic       hostOe;
    logic [7:0] hostDrv;
    logic [7:0] lastV = 8'h00;
    logic       strapTwoLevel = 1'b1;
    // Both straps high select the 8080 signalling; a scenario may drop strap two.
    assign busModeStrapOne = 1'b1;
    assign busModeStrapTwo = strapTwoLevel;
    // Undriven lines show a toggling pattern so stale data is never read back.
    assign busLine = parallelByteLinesOe ? parallelByteLinesOut : (hostOe ? hostDrv : ~lastV);
    always @(posedge core_clk) lastV <= busLine;
    initial begin
        chipSelN = 1'b1;
        wrStrobeN = 1'b1;
        rdStrobeN = 1'b1;
        dcSel = 1'b1;
        hostOe = 1'b0;
        hostDrv = 8'h00;
    end
    // One write; csFirst releases select before the strobe, as the t_data writes do.
    task automatic wr(input logic dc, input logic [7:0] b, input logic csFirst, input logic sel);
        dcSel <= dc;
        chipSelN <= ~sel;
        rdStrobeN <= 1'b1;
        @(posedge core_clk);
        wrStrobeN <= 1'b0;
        hostOe <= 1'b1;
        hostDrv <= b;
        repeat (3) @(posedge core_clk);
        if (csFirst) chipSelN <= 1'b1;
        else wrStrobeN <= 1'b1;
        @(posedge core_clk);
        chipSelN <= 1'b1;
        wrStrobeN <= 1'b1;
        @(posedge core_clk);
        hostOe <= 1'b0;
        dcSel <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    // One read; the byte is taken mid-cycle while the strobe is low.
    task automatic rd(input logic dc, input logic sel, output logic [7:0] v);
        dcSel <= dc;
        chipSelN <= ~sel;
        @(posedge core_clk);
        rdStrobeN <= 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) v = busLine;
        @(posedge core_clk);
        rdStrobeN <= 1'b1;
        @(posedge core_clk);
        chipSelN <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    // Sets strap two; the port takes the straps only after a reset release.
    task automatic set_straps(input logic two);
        strapTwoLevel <= two;
    endtask
endmodule
`default_nettype wire

// ===== bench/opw_port_test.sv
/* Self-checking bench of the parallel host port with a host model.
   Assumes the checker is bound in through its own file. */
`timescale 1ns/100ps
`default_nettype none
module opw_port_test;
    import opw_pkg::*;
    logic                core_clk;
    logic                arst_n;
    logic                outReady;
    logic [BYTE_W-1:0]   displayReadByte;
    logic [BYTE_W-1:0]   statusByte;
    logic [BYTE_W-1:0]   busLine;
    logic [BYTE_W-1:0]   parallelByteLinesOut;
    logic [BYTE_W-1:0]   outByte;
    logic [BYTE_W-1:0]   rdV;
    logic                chipSelN, wrStrobeN, rdStrobeN, dcSel, parallelByteLinesOe;
    logic                busModeStrapOne, busModeStrapTwo, outValid, outIsData;
    logic                readReq, readIsData, readDone, overrun, modeSelected;
    logic [WORD_W-1:0]   got[$];
    logic [WORD_W-1:0]   exp[$];
    int                  error_cnt, checks, ovCnt, rqCnt;
    opw_host_model opw_host_model_i (.core_clk, .parallelByteLinesOe, .parallelByteLinesOut,
        .chipSelN, .wrStrobeN, .rdStrobeN, .dcSel, .busLine, .busModeStrapOne, .busModeStrapTwo);
    opw_port opw_port_i (.core_clk, .arst_n, .chipSelN, .wrStrobeN, .rdStrobeN, .dcSel,
        .parallelByteLinesIn(busLine), .parallelByteLinesOut, .parallelByteLinesOe,
        .busModeStrapOne, .busModeStrapTwo, .outValid, .outReady, .outIsData, .outByte,
        .readReq, .readIsData, .readDone, .displayReadByte, .statusByte, .overrun, .modeSelected);
    initial begin
        core_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
    end
    // Collects accepted words and counts pulses.
    always @(posedge core_clk) begin
        if (arst_n === 1'b1) begin
            if (outValid === 1'b1 && outReady === 1'b1) got.push_back({outIsData, outByte});
            if (overrun === 1'b1) ovCnt++;
            if (readReq === 1'b1) rqCnt++;
        end
    end
    task automatic chk(input string n, input logic [WORD_W-1:0] s, input logic [WORD_W-1:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Waits for the expected words, then compares them in order.
    task automatic check_words;
        int n;
        n = 0;
        while (got.size() < exp.size() && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        if (got.size() < exp.size()) begin
            error_cnt++;
            wrap_up();
        end else begin
            repeat (8) @(posedge core_clk);
            chk("word count", WORD_W'(got.size()), WORD_W'(exp.size()));
            while (exp.size() > 0 && got.size() > 0) chk("word", got.pop_front(), exp.pop_front());
            got.delete();
            exp.delete();
        end
    endtask
    task automatic t_cmds;
        logic [7:0] seq[4] = '{8'hae, 8'h81, 8'hff, 8'haf};
        foreach (seq[i]) begin
            opw_host_model_i.wr(1'b0, seq[i], 1'b0, 1'b1);
            exp.push_back({1'b0, seq[i]});
        end
        check_words();
    endtask
    task automatic t_data;
        logic [7:0] seq[3] = '{8'h00, 8'hff, 8'h5a};
        foreach (seq[i]) begin
            opw_host_model_i.wr(1'b1, seq[i], 1'b1, 1'b1);
            exp.push_back({1'b1, seq[i]});
        end
        check_words();
    endtask
    task automatic t_read;
        displayReadByte <= 8'h3c;
        statusByte <= 8'hc3;
        opw_host_model_i.rd(1'b1, 1'b1, rdV);
        chk("data read", {1'b0, rdV}, 9'h03c);
        opw_host_model_i.rd(1'b0, 1'b1, rdV);
        chk("status read", {1'b0, rdV}, 9'h0c3);
    endtask
    task automatic t_ignore;
        rqCnt = 0;
        opw_host_model_i.wr(1'b0, 8'h11, 1'b0, 1'b0);
        opw_host_model_i.rd(1'b1, 1'b0, rdV);
        check_words();
        chk("unselected reads", WORD_W'(rqCnt), 9'h000);
    endtask
    // Straps not both high: nothing may be served until a reset with both high.
    task automatic t_nomode;
        rqCnt = 0;
        opw_host_model_i.set_straps(1'b0);
        arst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("mode off", {8'h00, modeSelected}, 9'h000);
        opw_host_model_i.wr(1'b0, 8'h3a, 1'b0, 1'b1);
        opw_host_model_i.rd(1'b1, 1'b1, rdV);
        check_words();
        chk("reads without mode", WORD_W'(rqCnt), 9'h000);
        opw_host_model_i.set_straps(1'b1);
        arst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("mode back", {8'h00, modeSelected}, 9'h001);
    endtask
    task automatic t_overrun;
        outReady <= 1'b0;
        ovCnt = 0;
        for (int i = 0; i < 7; i++) begin
            opw_host_model_i.wr(1'b1, 8'h20 + 8'(i), 1'b0, 1'b1);
            if (i < 6) exp.push_back({1'b1, 8'h20 + 8'(i)});
        end
        repeat (8) @(posedge core_clk);
        chk("overrun pulses", WORD_W'(ovCnt), 9'h001);
        outReady <= 1'b1;
        check_words();
    endtask
    task automatic t_midreset;
        fork
            opw_host_model_i.wr(1'b0, 8'h55, 1'b0, 1'b1);
            begin
                repeat (3) @(posedge core_clk);
                arst_n <= 1'b0;
            end
        join
        chk("reset flags", {4'h0, outValid, readReq, parallelByteLinesOe, overrun, modeSelected},
            9'h000);
        arst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        check_words();
        opw_host_model_i.wr(1'b0, 8'ha4, 1'b0, 1'b1);
        exp.push_back(9'h0a4);
        check_words();
    endtask
    initial begin
        error_cnt = 0;
        checks = 0;
        arst_n = 1'b0;
        outReady = 1'b1;
        displayReadByte = 8'h00;
        statusByte = 8'h00;
        // Reset held long before any transfer.
        repeat (10) @(posedge core_clk);
        chk("reset byte lines", {parallelByteLinesOe, parallelByteLinesOut}, 9'h000);
        chk("reset flags", {4'h0, outValid, readReq, readDone, overrun, modeSelected}, 9'h000);
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("mode", {8'h00, modeSelected}, 9'h001);
        t_cmds();
        t_data();
        t_read();
        t_ignore();
        t_nomode();
        t_overrun();
        t_midreset();
        wrap_up();
    end
endmodule
`default_nettype wire
